// >>> flow_warn.v
// Warning status logic of a mass flow controller: zero drift, bad zero,
// valve high/low, valve control instability, setpoint deviation, setpoint
// overrange and setpoint clamping, plus the live (clamped) setpoint.
// Assumes all inputs are synchronous to clk; zero events are one-cycle pulses.
//
// Behaviour
// - Drift warning: good zero, aged, excessive shift
// - Drift check only after setpoint settled at zero
// - Drift cleared on gas page change (set condition wins), disabled
// - Bad zero: zero done, setpoint zero, flow high
// - Bad zero cleared on zero start, disabled
// - Valve high trip with printed plus hysteresis
// - Valve low trip with plus hysteresis release
// - Valve position spread above limit, time qualified
// - Zero spread limit disables valve control warning
// - Flow outside half error band, time qualified
// - Deviation disabled: setpoint zero or flow invalid
// - Overrange warning for action raise, one second
// - Action codes: none, raise warning, clamp
// - Live setpoint clamped at the ceiling
// - Clamped warning for action clamp, one second
`timescale 1ns/1ps
`default_nettype none
`include "flow_warn_regs.vh"

module flow_warn #(
    parameter W = 16,
    parameter TW = 16,
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter AW = `STDDEV_ADDR_W
) (
    input wire clk,
    input wire arst_n,
    input wire [W-1:0] flow,
    input wire flow_valid,
    input wire [W-1:0] valve_pos,
    input wire [W-1:0] setpoint,
    input wire zero_start,
    input wire zero_done,
    input wire zero_ok,
    input wire [W-1:0] zero_shift,
    input wire gas_page_change,
    input wire [TW-1:0] zero_settle_time,
    input wire [31:0] min_drift_time,
    input wire [7:0] drift_mult,
    input wire [W-1:0] drift_add,
    input wire [W-1:0] zero_band,
    input wire [W-1:0] actuator_upper_trip,
    input wire [W-1:0] actuator_lower_trip,
    input wire [W-1:0] valve_hyst,
    input wire [W-1:0] valve_ctrl_limit,
    input wire [TW-1:0] valve_ctrl_settle,
    input wire [W-1:0] error_band,
    input wire [TW-1:0] ctrl_settle,
    input wire [W-1:0] target_ceiling,
    input wire [1:0] ceiling_action_select,
    output wire [`WARN_WIDTH-1:0] warnings,
    output wire target_deviation_flag,
    output wire target_overrange_flag,
    output wire target_clamped_flag,
    output reg [W-1:0] live_setpoint
);

    localparam NT = 5;
    localparam [W-1:0] DRIFT_STEP = `DRIFT_STEP;

    // Diagnostic tick: one-cycle enable every TICK_CYCLES clocks.
    reg [31:0] div_q;
    wire tick = (div_q == TICK_CYCLES - 1);
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 32'h0000_0000;
        end else if (tick) begin
            div_q <= 32'h0000_0000;
        end else begin
            div_q <= div_q + 32'h0000_0001;
        end
    end

    wire sp_zero = (setpoint == {W{1'b0}});
    wire act_raise = (ceiling_action_select == `ACTION_RAISE);
    wire act_clamp = (ceiling_action_select == `ACTION_CLAMP);

    // Live setpoint follows the command and is held at the ceiling when the
    // action asks for clamping; the other actions only watch the setpoint.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            live_setpoint <= {W{1'b0}};
        end else if (act_clamp && setpoint >= target_ceiling) begin
            live_setpoint <= target_ceiling;
        end else begin
            live_setpoint <= setpoint;
        end
    end

    // Rolling window of valve positions; sums feed the variance.
    reg [AW-1:0] ptr_q;
    reg full_q;
    reg [W+AW-1:0] sum_q;
    reg [2*W+AW-1:0] sq_q;
    wire [W-1:0] old_raw;
    wire [W-1:0] old_s = full_q ? old_raw : {W{1'b0}};
    wire [2*W-1:0] new_sq = valve_pos * valve_pos;
    wire [2*W-1:0] old_sq = old_s * old_s;

    sample_ring #(.W(W), .AW(AW)) u_ring (
        .clk(clk),
        .arst_n(arst_n),
        .we(tick),
        .waddr(ptr_q),
        .wdata(valve_pos),
        .raddr(ptr_q),
        .rdata(old_raw)
    );

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_q <= {AW{1'b0}};
            full_q <= 1'b0;
            sum_q <= {(W+AW){1'b0}};
            sq_q <= {(2*W+AW){1'b0}};
        end else if (tick) begin
            ptr_q <= ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (ptr_q == {AW{1'b1}}) begin
                full_q <= 1'b1;
            end
            sum_q <= sum_q + {{AW{1'b0}}, valve_pos} - {{AW{1'b0}}, old_s};
            sq_q <= sq_q + {{AW{1'b0}}, new_sq} - {{AW{1'b0}}, old_sq};
        end
    end

    // Variance against the squared limit avoids a square root; the truncated
    // mean never exceeds the true mean, so the difference stays positive.
    wire [W-1:0] mean = sum_q[W+AW-1:AW];
    wire [2*W-1:0] mean_sq = mean * mean;
    wire [2*W-1:0] var_w = sq_q[2*W+AW-1:AW] - mean_sq;
    wire [2*W-1:0] lim_sq = valve_ctrl_limit * valve_ctrl_limit;
    wire spread_high = (var_w > lim_sq);

    // Setpoint deviation band of plus or minus half the error band.
    wire [W-1:0] half_band = error_band >> 1;
    wire [W:0] band_hi = {1'b0, setpoint} + {1'b0, half_band};
    wire out_band = ({1'b0, flow} > band_hi) ||
                    (setpoint >= half_band && flow < setpoint - half_band);

    // Time-qualified conditions share one counter scheme:
    // 0 zero settle, 1 valve control, 2 deviation, 3 overrange, 4 clamped.
    wire [NT-1:0] want;
    wire [NT-1:0] hold;
    wire [NT-1:0] fast_clr;
    wire [NT-1:0] kill;
    wire [NT*TW-1:0] period;
    wire [NT-1:0] st;

    assign want[0] = sp_zero;
    assign want[1] = spread_high;
    assign want[2] = out_band;
    assign want[3] = (setpoint > target_ceiling);
    assign want[4] = (setpoint > target_ceiling);
    // At exactly the ceiling neither set nor clear applies: hold the bit.
    assign hold = {setpoint == target_ceiling, setpoint == target_ceiling, 3'b000};
    assign fast_clr = 5'h05;
    assign kill[0] = 1'b0;
    assign kill[1] = (valve_ctrl_limit == {W{1'b0}});
    assign kill[2] = sp_zero || !flow_valid;
    assign kill[3] = !act_raise;
    assign kill[4] = !act_clamp;
    assign period = {`ONE_SECOND_TICKS, `ONE_SECOND_TICKS, ctrl_settle, valve_ctrl_settle, zero_settle_time};

    genvar i;
    generate
        for (i = 0; i < NT; i = i + 1) begin : g_timer
            reg [TW-1:0] cnt_q;
            reg st_q;
            assign st[i] = st_q;
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cnt_q <= {TW{1'b0}};
                    st_q <= 1'b0;
                end else if (kill[i]) begin
                    cnt_q <= {TW{1'b0}};
                    st_q <= 1'b0;
                end else if (want[i] == st_q || hold[i]) begin
                    cnt_q <= {TW{1'b0}};
                end else if (!want[i] && fast_clr[i]) begin
                    cnt_q <= {TW{1'b0}};
                    st_q <= 1'b0;
                end else if (tick) begin
                    if (cnt_q > period[i*TW +: TW]) begin
                        cnt_q <= {TW{1'b0}};
                        st_q <= want[i];
                    end else begin
                        cnt_q <= cnt_q + {{(TW-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    endgenerate

    // Seconds since the last completed zero, successful or not, saturating.
    reg [15:0] sec_div_q;
    reg [31:0] since_zero_q;
    reg good_zero_q;
    wire sec_pulse = tick && (sec_div_q == `TICKS_PER_SECOND - 16'h0001);
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sec_div_q <= 16'h0000;
            since_zero_q <= 32'h0000_0000;
            good_zero_q <= 1'b0;
        end else begin
            if (zero_done) begin
                good_zero_q <= zero_ok;
                since_zero_q <= 32'h0000_0000;
                sec_div_q <= 16'h0000;
            end else if (tick) begin
                sec_div_q <= sec_pulse ? 16'h0000 : sec_div_q + 16'h0001;
                if (sec_pulse && since_zero_q != 32'hFFFF_FFFF) begin
                    since_zero_q <= since_zero_q + 32'h0000_0001;
                end
            end
        end
    end

    wire [W+8:0] drift_lim = DRIFT_STEP * drift_mult + {9'h000, drift_add};
    wire drift_off = (min_drift_time == 32'h0000_0000);
    wire drift_set = st[0] && sp_zero && good_zero_q && (since_zero_q > min_drift_time) &&
                     ({9'h000, zero_shift} > drift_lim);

    // Zero completion marker, dropped when a new zero starts.
    reg zero_cmpl_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zero_cmpl_q <= 1'b0;
        end else if (zero_done) begin
            zero_cmpl_q <= 1'b1;
        end else if (zero_start) begin
            zero_cmpl_q <= 1'b0;
        end
    end
    wire bad_off = (zero_band == {W{1'b0}});
    // A starting zero voids the previous completion, so its clear is never overridden.
    wire bad_set = zero_cmpl_q && !zero_start && sp_zero && (flow > zero_band);

    // Valve trip limits; the high release uses the plus sign as printed,
    // so above the trip point the set condition wins.
    wire [W:0] upper_rel = {1'b0, actuator_upper_trip} + {1'b0, valve_hyst};
    wire [W:0] lower_rel = {1'b0, actuator_lower_trip} + {1'b0, valve_hyst};

    reg drift_q;
    reg bad_q;
    reg vhi_q;
    reg vlo_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drift_q <= 1'b0;
            bad_q <= 1'b0;
            vhi_q <= 1'b0;
            vlo_q <= 1'b0;
        end else begin
            if (drift_off) begin
                drift_q <= 1'b0;
            end else if (drift_set) begin
                drift_q <= 1'b1;
            end else if (gas_page_change) begin
                drift_q <= 1'b0;
            end
            if (bad_off) begin
                bad_q <= 1'b0;
            end else if (bad_set) begin
                bad_q <= 1'b1;
            end else if (zero_start) begin
                bad_q <= 1'b0;
            end
            if (valve_pos > actuator_upper_trip) begin
                vhi_q <= 1'b1;
            end else if ({1'b0, valve_pos} < upper_rel) begin
                vhi_q <= 1'b0;
            end
            if (valve_pos < actuator_lower_trip) begin
                vlo_q <= 1'b1;
            end else if ({1'b0, valve_pos} > lower_rel) begin
                vlo_q <= 1'b0;
            end
        end
    end

    assign target_deviation_flag = st[2];
    assign target_overrange_flag = st[3];
    assign target_clamped_flag = st[4];

    generate
        for (i = 0; i < `WARN_WIDTH; i = i + 1) begin : g_warn
            if (i == `WARN_ZERO_DRIFT_BIT) begin : g_b
                assign warnings[i] = drift_q;
            end else if (i == `WARN_BAD_ZERO_BIT) begin : g_b
                assign warnings[i] = bad_q;
            end else if (i == `WARN_VALVE_HIGH_BIT) begin : g_b
                assign warnings[i] = vhi_q;
            end else if (i == `WARN_VALVE_LOW_BIT) begin : g_b
                assign warnings[i] = vlo_q;
            end else if (i == `WARN_VALVE_CTRL_BIT) begin : g_b
                assign warnings[i] = st[1];
            end else if (i == `WARN_DEVIATION_BIT) begin : g_b
                assign warnings[i] = st[2];
            end else if (i == `WARN_OVERRANGE_BIT) begin : g_b
                assign warnings[i] = st[3];
            end else if (i == `WARN_CLAMPED_BIT) begin : g_b
                assign warnings[i] = st[4];
            end else begin : g_b
                assign warnings[i] = 1'b0;
            end
        end
    endgenerate

endmodule // flow_warn

`default_nettype wire

// >>> flow_warn_monitor.sv
// Concurrent checks on the ports of the warning logic.
// Assumes the default 16-bit widths of the block.
`timescale 1ns/1ps
`default_nettype none
`include "flow_warn_regs.vh"

module flow_warn_monitor (
    input wire clk,
    input wire arst_n,
    input wire [15:0] flow,
    input wire flow_valid,
    input wire [15:0] valve_pos,
    input wire [15:0] setpoint,
    input wire [31:0] min_drift_time,
    input wire [15:0] zero_band,
    input wire [15:0] actuator_upper_trip,
    input wire [15:0] actuator_lower_trip,
    input wire [15:0] valve_ctrl_limit,
    input wire [15:0] error_band,
    input wire [15:0] target_ceiling,
    input wire [1:0] ceiling_action_select,
    input wire [15:0] warnings,
    input wire target_deviation_flag,
    input wire target_overrange_flag,
    input wire target_clamped_flag,
    input wire [15:0] live_setpoint
);
    // Band edges are widened to 17 bits so a large band cannot wrap.
    wire [16:0] hi_edge = {1'b0, setpoint} + {2'b00, error_band[15:1]};
    wire [16:0] lo_edge = {1'b0, flow} + {2'b00, error_band[15:1]};
    wire in_band = ({1'b0, flow} <= hi_edge) && (lo_edge >= {1'b0, setpoint});

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_FLAGS: assert property ({target_clamped_flag, target_overrange_flag, target_deviation_flag} ==
        {warnings[14], warnings[13], warnings[11]}) else $error("flag copies differ");
    AST_VALVE_HIGH: assert property (valve_pos > actuator_upper_trip |=> warnings[8])
        else $error("valve high not set");
    AST_VALVE_LOW: assert property (valve_pos < actuator_lower_trip |=> warnings[9])
        else $error("valve low not set");
    AST_VCTRL_OFF: assert property (valve_ctrl_limit == 16'h0000 |=> !warnings[10])
        else $error("valve control not disabled");
    AST_DEV_OFF: assert property (setpoint == 16'h0000 || !flow_valid |=> !warnings[11])
        else $error("deviation not disabled");
    AST_DEV_CLEAR: assert property (in_band |=> !warnings[11])
        else $error("deviation not cleared in band");
    AST_OVR_OFF: assert property (ceiling_action_select != 2'h1 |=> !warnings[13])
        else $error("overrange not cleared");
    AST_CLAMP_OFF: assert property (ceiling_action_select != 2'h2 |=> !warnings[14])
        else $error("clamped not cleared");
    AST_LIVE_CLAMP: assert property (ceiling_action_select == 2'h2 && setpoint >= target_ceiling
        |=> live_setpoint == $past(target_ceiling)) else $error("live setpoint not clamped");
    AST_LIVE_PASS: assert property (setpoint < target_ceiling |=> live_setpoint == $past(setpoint))
        else $error("live setpoint differs");
    AST_DRIFT_OFF: assert property (min_drift_time == 32'h00000000 |=> !warnings[4])
        else $error("drift not disabled");
    AST_BAD_ZERO_OFF: assert property (zero_band == 16'h0000 |=> !warnings[5])
        else $error("bad zero not disabled");
endmodule // flow_warn_monitor

bind flow_warn flow_warn_monitor mon (.clk(clk), .arst_n(arst_n), .flow(flow), .flow_valid(flow_valid),
    .valve_pos(valve_pos), .setpoint(setpoint), .min_drift_time(min_drift_time), .zero_band(zero_band),
    .actuator_upper_trip(actuator_upper_trip), .actuator_lower_trip(actuator_lower_trip),
    .valve_ctrl_limit(valve_ctrl_limit), .error_band(error_band), .target_ceiling(target_ceiling),
    .ceiling_action_select(ceiling_action_select), .warnings(warnings),
    .target_deviation_flag(target_deviation_flag), .target_overrange_flag(target_overrange_flag),
    .target_clamped_flag(target_clamped_flag), .live_setpoint(live_setpoint));

`default_nettype wire

// >>> flow_warn_regs.vh
// Constants for the flow controller warning logic: warning bit positions,
// setpoint ceiling action codes and time base figures.
// Assumes a 200 MHz device clock and a 1 ms diagnostic tick.
`ifndef FLOW_WARN_REGS_VH
`define FLOW_WARN_REGS_VH

// Warning vector bit positions.
`define WARN_ZERO_DRIFT_BIT 4
`define WARN_BAD_ZERO_BIT 5
`define WARN_VALVE_HIGH_BIT 8
`define WARN_VALVE_LOW_BIT 9
`define WARN_VALVE_CTRL_BIT 10
`define WARN_DEVIATION_BIT 11
`define WARN_OVERRANGE_BIT 13
`define WARN_CLAMPED_BIT 14
`define WARN_WIDTH 16
`define WARN_RESET 16'h0000

// Setpoint ceiling action codes.
`define ACTION_NONE 2'h0
`define ACTION_RAISE 2'h1
`define ACTION_CLAMP 2'h2

// Time base: clock period and diagnostic tick period in ns.
`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
// One second expressed in diagnostic ticks.
`define ONE_SECOND_MS 1000
`define ONE_SECOND_TICKS 16'h03E8
// Ticks per elapsed-time second for the zero drift timer.
`define TICKS_PER_SECOND 16'h03E8

// Full scale flow in counts and the drift rate of 0.2 %FS per year.
`define FULL_SCALE_COUNTS 32768
`define DRIFT_PERMILLE 2
`define DRIFT_STEP ((`FULL_SCALE_COUNTS * `DRIFT_PERMILLE) / 1000)

// Rolling window of valve position samples (log2 of depth).
`define STDDEV_ADDR_W 4

`endif

// >>> sample_ring.v
// Small sample memory for the rolling valve position window.
// One write port and one read port; read data come from a register.
`timescale 1ns/1ps
`default_nettype none

module sample_ring #(
    parameter W = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire arst_n,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [W-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [W-1:0] rdata
);

    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= {W{1'b0}};
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule // sample_ring

`default_nettype wire

// >>> status_host.sv
// Network host model that reads the warning word like a status attribute.
// Assumes the device clock and reset; a read returns the word one cycle later.
`timescale 1ns/1ps
`default_nettype none

module status_host (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic rd_en,
    input wire logic [15:0] status,
    output logic [15:0] rd_data_q
);
    // The host keeps its last read; it never reads the device combinationally.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) rd_data_q <= 16'h0000;
        else if (rd_en) rd_data_q <= status;
    end
endmodule // status_host

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the warning logic with a fast diagnostic tick.
// Assumes four clocks per tick, so one second is 4000 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) chk((a) === (e), a, e)

module testbench;
    localparam int TK = 4;
    logic clk, arst_n, flow_valid, zero_start, zero_done, zero_ok, gas_page_change, rd_en;
    logic [15:0] flow, valve_pos, setpoint, zero_shift, drift_add, zero_band, actuator_upper_trip;
    logic [15:0] actuator_lower_trip, valve_hyst, valve_ctrl_limit, error_band, target_ceiling;
    logic [15:0] zero_settle_time, valve_ctrl_settle, ctrl_settle, host_data;
    logic [31:0] min_drift_time;
    logic [7:0] drift_mult;
    logic [1:0] ceiling_action_select;
    wire [15:0] warnings, live_setpoint;
    wire target_deviation_flag, target_overrange_flag, target_clamped_flag;
    int num_errors = 0;
    int checks_done = 0;

    flow_warn #(.TICK_CYCLES(TK)) dut (.clk, .arst_n, .flow, .flow_valid, .valve_pos, .setpoint,
        .zero_start, .zero_done, .zero_ok, .zero_shift, .gas_page_change, .zero_settle_time,
        .min_drift_time, .drift_mult, .drift_add, .zero_band, .actuator_upper_trip, .actuator_lower_trip,
        .valve_hyst, .valve_ctrl_limit, .valve_ctrl_settle, .error_band, .ctrl_settle, .target_ceiling,
        .ceiling_action_select, .warnings, .target_deviation_flag, .target_overrange_flag,
        .target_clamped_flag, .live_setpoint);
    status_host host (.clk(clk), .arst_n(arst_n), .rd_en(rd_en), .status(warnings), .rd_data_q(host_data));

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    task chk(input bit ok, input logic [15:0] a, input logic [15:0] e);
        checks_done++;
        if (!ok) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task ticks(input int n);
        step(n * TK);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task t_valve;
        valve_pos = 16'h03E9; step(2); `CHK(warnings[8], 1'b1);
        valve_pos = 16'h03E8; step(2); `CHK(warnings[8], 1'b0);
        valve_pos = 16'h00C7; step(2); `CHK(warnings[9], 1'b1);
        valve_pos = 16'h012C; step(2); `CHK(warnings[9], 1'b1);
        valve_pos = 16'h012D; step(2); `CHK(warnings[9], 1'b0);
        valve_pos = 16'h01F4;
        $display("test valve trips done");
    endtask
    task t_bad_zero;
        zero_done = 1; step(1); zero_done = 0; step(2); `CHK(warnings[5], 1'b1);
        zero_start = 1; step(1); zero_start = 0; step(2); `CHK(warnings[5], 1'b0);
        zero_done = 1; step(1); zero_done = 0; zero_band = 16'h0000; step(2); `CHK(warnings[5], 1'b0);
        $display("test bad zero done");
    endtask
    task t_deviation;
        setpoint = 16'h03E8; flow = 16'h044D; ticks(3); `CHK(warnings[11], 1'b0);
        ticks(4); `CHK(warnings[11], 1'b1);
        rd_en = 1; step(1); rd_en = 0; step(1); `CHK(host_data, 16'h0800);
        flow = 16'h044C; step(2); `CHK(target_deviation_flag, 1'b0);
        flow = 16'h0383; ticks(7); `CHK(warnings[11], 1'b1);
        flow_valid = 0; step(2); `CHK(warnings[11], 1'b0);
        flow_valid = 1; ticks(7); setpoint = 16'h0000; step(2); `CHK(warnings[11], 1'b0);
        $display("test deviation done");
    endtask
    task t_ceiling;
        ceiling_action_select = 2'h1; setpoint = 16'h0258; step(2); `CHK(live_setpoint, 16'h0258);
        ticks(1000); `CHK(warnings[13], 1'b0);
        ticks(6); `CHK(target_overrange_flag, 1'b1);
        ceiling_action_select = 2'h2; step(2); `CHK(warnings[13], 1'b0);
        `CHK(live_setpoint, 16'h01F4);
        ticks(1006); `CHK(target_clamped_flag, 1'b1);
        setpoint = 16'h01F4; step(2); `CHK(live_setpoint, 16'h01F4);
        setpoint = 16'h0190; step(2); `CHK(live_setpoint, 16'h0190);
        ticks(1000); `CHK(warnings[14], 1'b1);
        ticks(6); `CHK(warnings[14], 1'b0);
        $display("test ceiling done");
    endtask
    task t_drift;
        setpoint = 16'h0000; min_drift_time = 1; zero_ok = 1; zero_done = 1; step(1);
        zero_done = 0; zero_ok = 0; ticks(1900); `CHK(warnings[4], 1'b0);
        ticks(1100); `CHK(warnings[4], 1'b1);
        zero_shift = 16'h004B; gas_page_change = 1; step(1); gas_page_change = 0;
        step(2); `CHK(warnings[4], 1'b0);
        zero_shift = 16'h004C; setpoint = 16'h0010; ticks(3); `CHK(warnings[4], 1'b0);
        setpoint = 16'h0000; ticks(1); `CHK(warnings[4], 1'b0);
        ticks(5); `CHK(warnings[4], 1'b1);
        min_drift_time = 0; step(2); `CHK(warnings[4], 1'b0);
        $display("test zero drift done");
    endtask
    task swing(input int n, input logic [15:0] amp);
        for (int i = 0; i < n; i++) begin
            valve_pos = i[0] ? 16'h0200 + amp : 16'h0200 - amp;
            ticks(1);
        end
    endtask
    task t_valve_ctrl;
        valve_ctrl_limit = 16'h0001; swing(30, 16'h0100); `CHK(warnings[10], 1'b1);
        swing(30, 16'h0000); `CHK(warnings[10], 1'b0);
        valve_ctrl_limit = 16'h0000; swing(30, 16'h0100); `CHK(warnings[10], 1'b0);
        $display("test valve control done");
    endtask

    initial begin
        arst_n = 0; flow_valid = 1; zero_start = 0; zero_done = 0; zero_ok = 0; gas_page_change = 0;
        rd_en = 0; flow = 16'h003C; valve_pos = 16'h01F4; setpoint = 16'h0000; zero_shift = 16'h004C;
        drift_add = 16'h000A; drift_mult = 8'h01; zero_band = 16'h0032; actuator_upper_trip = 16'h03E8;
        actuator_lower_trip = 16'h00C8; valve_hyst = 16'h0064; valve_ctrl_limit = 16'h0000;
        error_band = 16'h00C8; target_ceiling = 16'h01F4; zero_settle_time = 16'h0002;
        valve_ctrl_settle = 16'h0002; ctrl_settle = 16'h0003; min_drift_time = 0;
        ceiling_action_select = 2'h0;
        step(5);
        arst_n = 1;
        t_valve; t_bad_zero; t_deviation; t_ceiling; t_drift; t_valve_ctrl;
        end_of_test;
    end

    // The run needs about 25000 clocks; the margin covers a stuck diagnostic.
    initial begin
        #400000;
        num_errors++;
        end_of_test;
    end
endmodule // testbench

`default_nettype wire
